// ==== tpg_pkg.sv ====
`default_nettype none
package tpg_pkg;

    // Serial word layout
    localparam int unsigned SPI_WORD_W = 8;
    localparam int unsigned BIT_CNT_W = 3;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;

    // Command opcodes, upper three bits of a word
    localparam logic [2:0] OPC_NOP = 3'h0;
    localparam logic [2:0] OPC_DEADTIME = 3'h4;
    localparam logic [2:0] OPC_SIMULT = 3'h5;

    // Payload keys for the simultaneous-drive command
    localparam logic [4:0] SIMULT_KEY_ON = 5'h0A;
    localparam logic [4:0] SIMULT_KEY_OFF = 5'h00;

    // Reset values of the setup held by the core, deadtime counter floor and step
    localparam logic [4:0] DEADTIME_RST = 5'h0F;
    localparam logic SIMULT_RST = 1'b0;
    localparam logic [4:0] DEAD_ZERO = 5'h00;
    localparam logic [4:0] DEAD_STEP = 5'h01;

    // Reset values of the pin synchronisers
    localparam logic [11:0] PIN_SYNC_RST = 12'h380;

    // Received serial word
    typedef struct packed {
        logic [2:0] opcode;
        logic [4:0] payload;
    } tpg_cmd_s;

    // Setup steering the phase legs
    typedef struct packed {
        logic [4:0] deadtime;
        logic simult_en;
    } tpg_cfg_s;

    // Six gate-drive commands, bit 0 is phase A
    typedef struct packed {
        logic [2:0] high;
        logic [2:0] low;
    } tpg_gate_s;

    // Per-phase drive state
    typedef enum logic [2:0] {
        PH_OFF,
        PH_HIGH,
        PH_LOW,
        PH_BOTH,
        PH_DEAD
    } tpg_phase_e;

endpackage
`default_nettype wire

// ==== tpg_predrive.sv ====
`timescale 1ns/10ps
`default_nettype none

// Two-flop synchroniser for a group of pin levels
module tpg_sync #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and resets
    input wire logic clk_sys_i,
    input wire logic rst_async_i,
    input wire logic sys_rst_i,
    // Levels
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_reg, sync_reg;
    // First flop feeds only the second
    always_ff @(posedge clk_sys_i or posedge rst_async_i) begin
        if (rst_async_i) begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end else if (sys_rst_i) begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end
    assign sync_o = sync_reg;
endmodule

// One phase: high and low gate with deadtime between them
module tpg_phase_leg
    import tpg_pkg::*;
(
    // Clock and resets
    input wire logic clk_sys_i,
    input wire logic rst_async_i,
    input wire logic sys_rst_i,
    // Requests and setup
    input wire logic gate_en_i,
    input wire logic high_req_i,
    input wire logic low_req_i,
    input wire tpg_cfg_s cfg_i,
    // Gate drive
    output logic high_on_o,
    output logic low_on_o
);
    tpg_phase_e state_reg, state_next;
    logic [4:0] dead_cnt_reg, dead_cnt_next;
    logic high_on_reg, low_on_reg;
    logic high_want, low_want, both_want, enter_dead, dead_done;
    // Wanted sides; conflicting requests cancel unless permitted
    assign both_want = high_req_i & low_req_i;
    assign high_want = gate_en_i & high_req_i
        & (~low_req_i | cfg_i.simult_en);
    assign low_want = gate_en_i & low_req_i
        & (~high_req_i | cfg_i.simult_en);
    assign dead_done = (dead_cnt_reg == DEAD_ZERO);
    assign enter_dead = (state_reg != PH_DEAD) & (state_next == PH_DEAD);
    // Next drive state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PH_OFF: begin
                if (high_want & low_want) begin
                    state_next = PH_BOTH;
                end else if (high_want) begin
                    state_next = PH_HIGH;
                end else if (low_want) begin
                    state_next = PH_LOW;
                end
            end
            PH_HIGH: begin
                if (high_want & low_want) begin
                    state_next = PH_BOTH;
                end else if (!high_want) begin
                    state_next = PH_DEAD;
                end
            end
            PH_LOW: begin
                if (high_want & low_want) begin
                    state_next = PH_BOTH;
                end else if (!low_want) begin
                    state_next = PH_DEAD;
                end
            end
            PH_BOTH: begin
                if (!(high_want & low_want & both_want)) begin
                    state_next = PH_DEAD;
                end
            end
            PH_DEAD: begin
                if (dead_done) begin
                    state_next = PH_OFF;
                end
            end
            default: begin
                state_next = PH_OFF;
            end
        endcase
    end
    // Deadtime counter loads on every turn-off
    always_comb begin
        dead_cnt_next = dead_cnt_reg;
        if (enter_dead) begin
            dead_cnt_next = cfg_i.deadtime;
        end else if (state_reg == PH_DEAD && !dead_done) begin
            dead_cnt_next = dead_cnt_reg - DEAD_STEP;
        end
    end
    // State, counter and registered gate outputs
    always_ff @(posedge clk_sys_i or posedge rst_async_i) begin
        if (rst_async_i) begin
            state_reg <= PH_OFF;
            dead_cnt_reg <= DEAD_ZERO;
            high_on_reg <= 1'b0;
            low_on_reg <= 1'b0;
        end else if (sys_rst_i) begin
            state_reg <= PH_OFF;
            dead_cnt_reg <= DEAD_ZERO;
            high_on_reg <= 1'b0;
            low_on_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            dead_cnt_reg <= dead_cnt_next;
            high_on_reg <= (state_next == PH_HIGH)
                | (state_next == PH_BOTH);
            low_on_reg <= (state_next == PH_LOW)
                | (state_next == PH_BOTH);
        end
    end
    assign high_on_o = high_on_reg;
    assign low_on_o = low_on_reg;
endmodule

// Pre-driver control core
module tpg_predrive
    import tpg_pkg::*;
(
    // System clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Host reset and enables
    input wire logic device_reset_n_i,
    input wire logic drive_enable_a_i,
    input wire logic drive_enable_b_i,
    // Direct phase commands
    input wire logic phase_a_high_cmd_n_i,
    input wire logic phase_b_high_cmd_n_i,
    input wire logic phase_c_high_cmd_n_i,
    input wire logic phase_a_low_cmd_i,
    input wire logic phase_b_low_cmd_i,
    input wire logic phase_c_low_cmd_i,
    // Serial setup port
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_si_i,
    output logic spi_so_o,
    output logic spi_so_oe_o,
    // Comparator results from the analog side
    input wire logic phase_a_high_source_above_i,
    input wire logic phase_b_high_source_above_i,
    input wire logic phase_c_high_source_above_i,
    input wire logic overcurrent_cmp_i,
    // Outputs to the drivers and the host
    output tpg_gate_s gate_drive_o,
    output logic phase_a_level_out_o,
    output logic phase_b_level_out_o,
    output logic phase_c_level_out_o,
    output logic overcurrent_flag_out_o,
    output logic interrupt_o
);
    logic [1:0] rst_pipe_reg;
    logic dev_rst, gate_en, oc_sync, oc_prev_reg, oc_rise, link_rst;
    logic [11:0] pin_sync;
    logic [2:0] high_req, low_req, bit_cnt_reg;
    logic [7:0] shift_reg, hold_reg;
    logic word_tgl_reg, tgl_sync, tgl_prev_reg, word_evt;
    tpg_cmd_s cmd;
    logic is_nop, is_dt, is_sim_on, is_sim_off, cmd_good, cmd_bad;
    tpg_cfg_s cfg_reg;
    logic int_reg;
    logic [2:0] high_on, low_on;
    // Host reset: asserts at once, releases on the clock
    always_ff @(posedge clk_sys_i or negedge device_reset_n_i) begin
        if (!device_reset_n_i) begin
            rst_pipe_reg <= 2'h0;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end

    assign dev_rst = ~rst_pipe_reg[1];

    // Pin levels into the system clock
    tpg_sync #(
        .W(12),
        .RST_VAL(PIN_SYNC_RST)
    ) u_pin_sync (
        .clk_sys_i(clk_sys_i),
        .rst_async_i(dev_rst),
        .sys_rst_i(sys_rst_i),
        .async_i({drive_enable_a_i, drive_enable_b_i,
            phase_c_high_cmd_n_i, phase_b_high_cmd_n_i,
            phase_a_high_cmd_n_i, phase_c_low_cmd_i,
            phase_b_low_cmd_i, phase_a_low_cmd_i,
            phase_c_high_source_above_i, phase_b_high_source_above_i,
            phase_a_high_source_above_i, overcurrent_cmp_i}),
        .sync_o(pin_sync)
    );

    // Command decode from the synchronised pins
    assign gate_en = pin_sync[11] & pin_sync[10];
    assign high_req = ~pin_sync[9:7];
    assign low_req = pin_sync[6:4];
    assign oc_sync = pin_sync[0];

    // Comparator levels straight from synchroniser flops
    assign phase_a_level_out_o = pin_sync[1];
    assign phase_b_level_out_o = pin_sync[2];
    assign phase_c_level_out_o = pin_sync[3];
    assign overcurrent_flag_out_o = oc_sync;

    // Serial link: bit count cleared outside a frame
    assign link_rst = spi_cs_n_i | ~device_reset_n_i;

    always_ff @(negedge spi_sclk_i or posedge link_rst) begin
        if (link_rst) begin
            bit_cnt_reg <= BIT_FIRST;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
    end

    // Shift in on the falling edge, most significant bit first
    always_ff @(negedge spi_sclk_i or negedge device_reset_n_i) begin
        if (!device_reset_n_i) begin
            shift_reg <= 8'h00;
        end else if (!spi_cs_n_i) begin
            shift_reg <= {shift_reg[6:0], spi_si_i};
        end
    end

    // Completed word held for the system side, flagged by toggle
    always_ff @(negedge spi_sclk_i or negedge device_reset_n_i) begin
        if (!device_reset_n_i) begin
            hold_reg <= 8'h00;
            word_tgl_reg <= 1'b0;
        end else if (!spi_cs_n_i && bit_cnt_reg == BIT_LAST) begin
            hold_reg <= {shift_reg[6:0], spi_si_i};
            word_tgl_reg <= ~word_tgl_reg;
        end
    end

    // Data out echoes the previous word; driven only in a frame
    assign spi_so_o = shift_reg[7];
    assign spi_so_oe_o = ~spi_cs_n_i;

    // Word toggle into the system clock
    tpg_sync #(
        .W(1),
        .RST_VAL(1'b0)
    ) u_tgl_sync (
        .clk_sys_i(clk_sys_i),
        .rst_async_i(dev_rst),
        .sys_rst_i(sys_rst_i),
        .async_i(word_tgl_reg),
        .sync_o(tgl_sync)
    );

    // Edge memory for toggle and over-current
    always_ff @(posedge clk_sys_i or posedge dev_rst) begin
        if (dev_rst) begin
            tgl_prev_reg <= 1'b0;
            oc_prev_reg <= 1'b0;
        end else if (sys_rst_i) begin
            tgl_prev_reg <= 1'b0;
            oc_prev_reg <= 1'b0;
        end else begin
            tgl_prev_reg <= tgl_sync;
            oc_prev_reg <= oc_sync;
        end
    end

    // Command decode; hold word is stable when the toggle lands
    assign word_evt = tgl_sync ^ tgl_prev_reg;
    assign cmd = tpg_cmd_s'(hold_reg);
    assign is_nop = (cmd.opcode == OPC_NOP);
    assign is_dt = (cmd.opcode == OPC_DEADTIME);
    assign is_sim_on = (cmd.opcode == OPC_SIMULT)
        & (cmd.payload == SIMULT_KEY_ON);
    assign is_sim_off = (cmd.opcode == OPC_SIMULT)
        & (cmd.payload == SIMULT_KEY_OFF);
    assign cmd_good = word_evt & (is_nop | is_dt | is_sim_on | is_sim_off);
    assign cmd_bad = word_evt & ~(is_nop | is_dt | is_sim_on | is_sim_off);
    assign oc_rise = oc_sync & ~oc_prev_reg;

    // Setup registers written by serial commands
    always_ff @(posedge clk_sys_i or posedge dev_rst) begin
        if (dev_rst) begin
            cfg_reg.deadtime <= DEADTIME_RST;
            cfg_reg.simult_en <= SIMULT_RST;
        end else if (sys_rst_i) begin
            cfg_reg.deadtime <= DEADTIME_RST;
            cfg_reg.simult_en <= SIMULT_RST;
        end else begin
            if (word_evt && is_dt) begin
                cfg_reg.deadtime <= cmd.payload;
            end
            if (word_evt && is_sim_on) begin
                cfg_reg.simult_en <= 1'b1;
            end else if (word_evt && is_sim_off) begin
                cfg_reg.simult_en <= 1'b0;
            end
        end
    end

    // Interrupt: over-current or bad word sets, good word clears
    always_ff @(posedge clk_sys_i or posedge dev_rst) begin
        if (dev_rst) begin
            int_reg <= 1'b0;
        end else if (sys_rst_i) begin
            int_reg <= 1'b0;
        end else if (oc_rise || cmd_bad) begin
            int_reg <= 1'b1;
        end else if (cmd_good) begin
            int_reg <= 1'b0;
        end
    end

    assign interrupt_o = int_reg;

    // Three phase legs
    for (genvar p = 0; p < 3; p++) begin : g_leg
        tpg_phase_leg u_leg (
            .clk_sys_i(clk_sys_i),
            .rst_async_i(dev_rst),
            .sys_rst_i(sys_rst_i),
            .gate_en_i(gate_en),
            .high_req_i(high_req[p]),
            .low_req_i(low_req[p]),
            .cfg_i(cfg_reg),
            .high_on_o(high_on[p]),
            .low_on_o(low_on[p])
        );
    end
    // One driver for the whole gate word
    assign gate_drive_o = tpg_gate_s'({high_on, low_on});
endmodule

`default_nettype wire

// ==== tpg_predrive_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module tpg_predrive_sva
    import tpg_pkg::*;
(
    // Clock and resets
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic device_reset_n_i,
    // Pins in
    input wire logic drive_enable_a_i,
    input wire logic drive_enable_b_i,
    input wire logic phase_a_high_cmd_n_i,
    input wire logic phase_a_low_cmd_i,
    input wire logic spi_cs_n_i,
    input wire logic phase_a_high_source_above_i,
    input wire logic overcurrent_cmp_i,
    // Pins out
    input wire logic spi_so_oe_o,
    input wire tpg_gate_s gate_drive_o,
    input wire logic phase_a_level_out_o,
    input wire logic overcurrent_flag_out_o,
    input wire logic interrupt_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i || !device_reset_n_i);

    // Cycles since reset, saturating
    logic [2:0] up_reg;
    always_ff @(posedge clk_sys_i or negedge device_reset_n_i) begin
        if (!device_reset_n_i) begin
            up_reg <= 3'h0;
        end else if (sys_rst_i) begin
            up_reg <= 3'h0;
        end else if (up_reg != 3'h7) begin
            up_reg <= up_reg + 3'h1;
        end
    end
    wire logic settled = (up_reg == 3'h7);
    wire logic both_en = drive_enable_a_i && drive_enable_b_i;

    a_enable_gate_off: assert property (
        (!both_en) [*3] |=> gate_drive_o == '0)
        else $error("gate on with an enable low");
    a_enable_and_on: assert property (
        $rose(gate_drive_o.high[0]) || $rose(gate_drive_o.low[0])
        |-> $past(both_en, 3)) else $error("gate on without enables");
    a_high_req_low: assert property (
        $rose(gate_drive_o.high[0]) |-> !$past(phase_a_high_cmd_n_i, 3))
        else $error("high side on without request");
    a_low_req_high: assert property (
        $rose(gate_drive_o.low[0]) |-> $past(phase_a_low_cmd_i, 3))
        else $error("low side on without request");
    a_dead_after_high: assert property (
        $fell(gate_drive_o.high[0]) |-> (!gate_drive_o.low[0]) [*2])
        else $error("no dead time after high side");
    a_so_drive_cs: assert property (
        spi_so_oe_o == !spi_cs_n_i) else $error("SO drive wrong");
    a_phase_level: assert property (
        settled |-> phase_a_level_out_o
        == $past(phase_a_high_source_above_i, 2))
        else $error("phase level wrong");
    a_oc_follow: assert property (
        settled |-> overcurrent_flag_out_o == $past(overcurrent_cmp_i, 2))
        else $error("overcurrent flag wrong");
    a_async_reset_off: assert property (disable iff (sys_rst_i)
        !device_reset_n_i |-> gate_drive_o == '0 && !interrupt_o)
        else $error("outputs live in host reset");
    a_oc_interrupt: assert property (
        settled && $rose(overcurrent_flag_out_o) |-> ##[0:2] interrupt_o)
        else $error("no interrupt on overcurrent");

    // Main scenarios seen
    c_high_on: cover property ($rose(gate_drive_o.high[0]));
    c_both_on: cover property (gate_drive_o.high[0] && gate_drive_o.low[0]);
    c_irq: cover property ($rose(interrupt_o));
endmodule
`default_nettype wire

// ==== tpg_spi_host.sv ====
`timescale 1ns/10ps
`default_nettype none
// Host side of the serial setup port
module tpg_spi_host (
    // Serial lines
    output logic sclk_o,
    output logic cs_n_o,
    output logic si_o,
    input wire logic so_i
);
    // Idle: clock parked low, frame closed
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b0;
        si_o = 1'b0;
        // Empty frame closed at start clears the bit count
        #1 cs_n_o = 1'b1;
    end
    // One framed word, MSB first, SO taken on the rising edge
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        cs_n_o = 1'b0;
        #6;
        for (int i = 7; i >= 0; i--) begin
            #1 si_o = tx[i];
            #2 sclk_o = 1'b1;
            rx[i] = so_i;
            #3 sclk_o = 1'b0;
        end
        #3 cs_n_o = 1'b1;
        si_o = ~si_o;
    endtask
endmodule
`default_nettype wire

// ==== tpg_predrive_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module tpg_predrive_test
    import tpg_pkg::*;
;
    logic clk_sys_i = 0, sys_rst_i = 1, device_reset_n_i = 1, oc = 0;
    logic [1:0] en = 2'h3;
    logic [2:0] hn = 3'h7, lo = 3'h0, src = 3'h0;
    logic spi_sclk_i, spi_cs_n_i, spi_si_i, spi_so_o, spi_so_oe_o;
    logic [2:0] lvl;
    logic overcurrent_flag_out_o, interrupt_o;
    logic [7:0] rx;
    tpg_gate_s gate;
    int checks = 0, bad_count = 0, cyc = 0;
    wire logic so_line = spi_so_oe_o ? spi_so_o : 1'bz;

    tpg_predrive DUT (.clk_sys_i, .sys_rst_i, .device_reset_n_i,
        .drive_enable_a_i(en[0]), .drive_enable_b_i(en[1]),
        .phase_a_high_cmd_n_i(hn[0]), .phase_a_low_cmd_i(lo[0]),
        .phase_b_high_cmd_n_i(hn[1]), .phase_b_low_cmd_i(lo[1]),
        .phase_c_high_cmd_n_i(hn[2]), .phase_c_low_cmd_i(lo[2]),
        .spi_sclk_i, .spi_cs_n_i, .spi_si_i, .spi_so_o, .spi_so_oe_o,
        .phase_a_high_source_above_i(src[0]),
        .phase_b_high_source_above_i(src[1]),
        .phase_c_high_source_above_i(src[2]),
        .overcurrent_cmp_i(oc), .gate_drive_o(gate),
        .phase_a_level_out_o(lvl[0]), .phase_b_level_out_o(lvl[1]),
        .phase_c_level_out_o(lvl[2]), .overcurrent_flag_out_o,
        .interrupt_o);
    tpg_spi_host host (.sclk_o(spi_sclk_i), .cs_n_o(spi_cs_n_i),
        .si_o(spi_si_i), .so_i(so_line));

    // System clock
    initial begin
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    // Hang guard
    initial begin
        forever begin
            @(posedge clk_sys_i);
            cyc++;
            if (cyc == 20000) begin
                bad_count++;
                test_done;
            end
        end
    end

    // Expected gates: conflict blocks both unless simultaneous is on
    function automatic tpg_gate_s exp_gate(input logic [2:0] h, l,
        input logic e, s);
        tpg_gate_s g;
        g.high = {3{e}} & ~h & (~l | {3{s}});
        g.low = {3{e}} & l & (h | {3{s}});
        return g;
    endfunction
    task automatic check(input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic drive(input logic [2:0] h, l, input logic [1:0] e);
        @(posedge clk_sys_i);
        hn <= h;
        lo <= l;
        en <= e;
    endtask
    task automatic send(input logic [2:0] op, input logic [4:0] pl);
        host.xfer({op, pl}, rx);
        tick(6);
    endtask
    // Low to high switch on phase A, dead gap measured in cycles
    task automatic gap(input logic [4:0] d);
        int n;
        drive(3'h7, 3'h1, 2'h3);
        tick(40);
        drive(3'h6, 3'h0, 2'h3);
        n = 0;
        while (gate.low[0] !== 1'b0 && n < 60) begin
            tick(1);
            n++;
        end
        n = 0;
        while (gate.high[0] !== 1'b1 && n < 60) begin
            tick(1);
            n++;
        end
        check(n, d + 2);
    endtask
    task test_done;
        $display("checks %0d errors %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        void'($urandom(9));
        device_reset_n_i <= 1'b0;
        repeat (10) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        device_reset_n_i <= 1'b1;
        tick(10);
        gap(DEADTIME_RST);
        send(OPC_DEADTIME, DEAD_ZERO);
        gap(DEAD_ZERO);
        send(OPC_NOP, 5'h00);
        send(OPC_DEADTIME, 5'h05);
        gap(5'h05);
        send(OPC_SIMULT, 5'h0B);
        check(interrupt_o, 1'b1);
        send(OPC_SIMULT, SIMULT_KEY_ON);
        check(interrupt_o, 1'b0);
        check(spi_so_oe_o, 1'b0);
        drive(3'h0, 3'h7, 2'h3);
        tick(40);
        check(gate, exp_gate(3'h0, 3'h7, 1'b1, 1'b1));
        send(OPC_SIMULT, SIMULT_KEY_OFF);
        check(rx, {OPC_SIMULT, SIMULT_KEY_ON});
        tick(40);
        check(gate, exp_gate(3'h0, 3'h7, 1'b1, 1'b0));
        for (int i = 0; i < 4; i++) begin
            drive(3'h7, 3'h7, 2'(i));
            tick(40);
            check(gate, exp_gate(3'h7, 3'h7, i == 3, 1'b0));
        end
        for (int i = 0; i < 16; i++) begin
            drive(3'($urandom), 3'($urandom), 2'($urandom | 1));
            tick(40);
            check(gate, exp_gate(hn, lo, &en, 1'b0));
        end
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys_i);
            src <= 3'($urandom);
            oc <= 1'($urandom);
            tick(4);
            check(lvl, src);
            check(overcurrent_flag_out_o, oc);
        end
        send(OPC_NOP, 5'h00);
        check(interrupt_o, 1'b0);
        @(posedge clk_sys_i);
        oc <= ~oc;
        tick(6);
        @(posedge clk_sys_i);
        oc <= ~oc;
        tick(6);
        check(interrupt_o, 1'b1);
        #30 device_reset_n_i = 1'b0;
        #5 check(gate, '0);
        @(posedge clk_sys_i);
        device_reset_n_i <= 1'b1;
        tick(10);
        gap(DEADTIME_RST);
        test_done;
    end
endmodule

bind tpg_predrive tpg_predrive_sva u_sva (.clk_sys_i, .sys_rst_i,
    .device_reset_n_i, .drive_enable_a_i, .drive_enable_b_i,
    .phase_a_high_cmd_n_i, .phase_a_low_cmd_i, .spi_cs_n_i,
    .phase_a_high_source_above_i, .overcurrent_cmp_i, .spi_so_oe_o,
    .gate_drive_o, .phase_a_level_out_o, .overcurrent_flag_out_o,
    .interrupt_o);
`default_nettype wire
